// ==== design/sfc_pkg.sv ====
// Shared constants, types and helper functions of the serial flash command front end
package sfc_pkg;

  // Frame layout: opcode, then three address bytes, MSB first
  localparam int OP_W       = 8;
  localparam int RSV_W      = 3;
  localparam int PAGE_W     = 12;
  localparam int OFF_W      = 9;
  localparam int ADDR_W     = RSV_W + PAGE_W + OFF_W;
  localparam int FRAME_W    = OP_W + ADDR_W;
  localparam int CNT_W      = 6;
  localparam int PAGE_LSB   = OFF_W;
  localparam int STAT_READY = 7;

  // Reset values
  localparam logic       MODE3_RST = 1'b1;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  // Timing
  localparam longint CLK_HZ      = 200_000_000;
  localparam longint T_PUW_MS    = 3;
  localparam int     PUW_CYC     = int'((T_PUW_MS * CLK_HZ) / 1000);
  localparam int     PUW_CNT_W   = 20;

  // Opcodes
  localparam logic [7:0] OP_MM_PROG_NE  = 8'h02;
  localparam logic [7:0] OP_BLK_ERASE   = 8'h50;
  localparam logic [7:0] OP_REWRITE_1   = 8'h58;
  localparam logic [7:0] OP_REWRITE_2   = 8'h59;
  localparam logic [7:0] OP_SECT_ERASE  = 8'h7c;
  localparam logic [7:0] OP_PAGE_ERASE  = 8'h81;
  localparam logic [7:0] OP_PROG_ERA_1  = 8'h82;
  localparam logic [7:0] OP_BUF1_PROG_E = 8'h83;
  localparam logic [7:0] OP_PROG_ERA_2  = 8'h85;
  localparam logic [7:0] OP_BUF2_PROG_E = 8'h86;
  localparam logic [7:0] OP_BUF1_PROG   = 8'h88;
  localparam logic [7:0] OP_BUF2_PROG   = 8'h89;
  localparam logic [7:0] OP_STATUS      = 8'hd7;

  typedef enum logic [2:0] {CL_UNKNOWN, CL_PAGE_BYTE, CL_PAGE, CL_BYTE, CL_DUMMY} sfc_class_t;
  typedef enum logic {PWR_OFF, PWR_STANDBY} sfc_pwr_t;

  // Opcodes that carry no address bytes at all
  function automatic logic sfc_no_addr(input logic [7:0] op);
    case (op)
      8'h79, 8'h9f, 8'hb9, 8'hab, 8'hb0, 8'hd0, 8'hd7: sfc_no_addr = 1'b1;
      default:                                          sfc_no_addr = 1'b0;
    endcase
  endfunction

  // Opcodes that start a program or erase of the array
  function automatic logic sfc_is_pe(input logic [7:0] op);
    case (op)
      OP_MM_PROG_NE, OP_BLK_ERASE, OP_REWRITE_1, OP_REWRITE_2, OP_SECT_ERASE,
      OP_PAGE_ERASE, OP_PROG_ERA_1, OP_BUF1_PROG_E, OP_PROG_ERA_2,
      OP_BUF2_PROG_E, OP_BUF1_PROG, OP_BUF2_PROG: sfc_is_pe = 1'b1;
      default:                                    sfc_is_pe = 1'b0;
    endcase
  endfunction

endpackage

// ==== design/sfc_sync.sv ====
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module sfc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= '0;
      o_q    <= '0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule // sfc_sync

// ==== design/sfc_addr_dec.sv ====
// Splits the three address bytes into page and byte fields per opcode
`timescale 1ns/1ps
module sfc_addr_dec
  import sfc_pkg::*;
(
  input  wire logic [OP_W-1:0]   i_op,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_rmw,
  output logic      [PAGE_W-1:0] o_page,
  output logic      [OFF_W-1:0]  o_off,
  output logic                   o_has_page,
  output logic                   o_has_off,
  output logic                   o_known
);
  sfc_class_t          cls;
  logic [PAGE_W-1:0]   page_mask;
  logic [PAGE_W-1:0]   page_raw;

  // Reserved bits are never looked at
  assign page_raw = i_addr[PAGE_LSB +: PAGE_W];

  // Field class of each opcode in the 264-byte page layout
  always_comb begin
    page_mask = {PAGE_W{1'b1}};
    case (i_op)
      8'h01, 8'h02, 8'h03, 8'h0b, 8'h1b, 8'h82, 8'h85, 8'hd2: cls = CL_PAGE_BYTE;
      OP_REWRITE_1, OP_REWRITE_2: cls = i_rmw ? CL_PAGE_BYTE : CL_PAGE;
      8'h53, 8'h55, 8'h60, 8'h61, 8'h81, 8'h83, 8'h86, 8'h88, 8'h89: cls = CL_PAGE;
      OP_BLK_ERASE: begin
        cls       = CL_PAGE;
        page_mask = 12'hff8;    // Block granularity, low page bits ignored
      end
      OP_SECT_ERASE: begin
        cls       = CL_PAGE;
        page_mask = 12'hf00;    // Sector granularity
      end
      8'h84, 8'h87, 8'hd1, 8'hd3, 8'hd4, 8'hd6: cls = CL_BYTE;
      8'h32, 8'h35, 8'h77, 8'h79, 8'h9f, 8'hb9, 8'hab, 8'hb0, 8'hd0, 8'hd7: cls = CL_DUMMY;
      default: cls = CL_UNKNOWN;
    endcase
  end

  // Don't-care positions read as zero downstream
  always_comb begin
    o_has_page = (cls == CL_PAGE_BYTE) || (cls == CL_PAGE);
    o_has_off  = (cls == CL_PAGE_BYTE) || (cls == CL_BYTE);
    o_known    = (cls != CL_UNKNOWN);
    o_page     = o_has_page ? (page_raw & page_mask) : '0;
    o_off      = o_has_off ? i_addr[OFF_W-1:0] : '0;
  end
endmodule // sfc_addr_dec

// ==== design/sfc_top.sv ====
// Serial flash command front end: SPI frame capture, address split and power-up state
`timescale 1ns/1ps
module sfc_top
  import sfc_pkg::*;
#(
  parameter int PUW_CYCLES = PUW_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_ce,
  input  wire logic              i_por,
  input  wire logic              i_rmw_sel,
  input  wire logic              i_sck,
  input  wire logic              i_cs_n,
  input  wire logic              i_si,
  output logic                   o_so,
  output logic                   o_so_oe,
  output logic                   o_cmd_valid,
  output logic      [OP_W-1:0]   o_opcode,
  output logic      [PAGE_W-1:0] o_page,
  output logic      [OFF_W-1:0]  o_offset,
  output logic                   o_has_page,
  output logic                   o_has_offset,
  output logic                   o_cmd_known,
  output logic                   o_mode3,
  output logic                   o_standby,
  output logic                   o_pe_allowed
);

  // Two clock domains meet here. The serial clock runs only while the host frames a
  // command, so nothing on the link side may wait for a free-running edge: the frame
  // logic clears on select rising, and the finished frame leaves as a word plus a toggle.
  // The core sees the toggle through two flops and reads the word directly. The word is
  // written once, on the completing edge, and then holds until the next frame completes.
  // Frames must therefore stay apart by more than the synchroniser latency, which the
  // minimum select-high time already guarantees.
  //
  // Limitation: the status byte carries only the standby level, taken through a
  // synchroniser clocked by the serial clock. Its first edges after reset may still
  // show the reset value, so a status read straight after reset can report busy.
  //
  // Trade-off: mode detection runs in the core domain from synced copies of select
  // and clock. This costs two or three core cycles after the fall, but the host
  // leaves the clock idle for far longer than that.

  // ---------------- Link domain (serial clock) ----------------
  logic [FRAME_W-1:0] lk_shift_r;
  logic [CNT_W-1:0]   lk_cnt_r;
  logic               lk_status_r;
  logic [FRAME_W-1:0] lk_word_r;
  logic               lk_tgl_r;
  logic [7:0]         lk_tx_r;
  logic               lk_ready_s;
  logic [7:0]         lk_op_now;
  logic               lk_op_end;
  logic               lk_addr_end;

  // Opcode as it completes on the eighth rising edge
  assign lk_op_now   = {lk_shift_r[6:0], i_si};
  assign lk_op_end   = (lk_cnt_r == CNT_W'(OP_W - 1));
  assign lk_addr_end = (lk_cnt_r == CNT_W'(FRAME_W - 1));

  // Shift in while selected; a raised select clears the frame so only a fresh fall starts one
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      lk_shift_r  <= '0;
      lk_cnt_r    <= '0;
      lk_status_r <= 1'b0;
    end else begin
      lk_shift_r <= {lk_shift_r[FRAME_W-2:0], i_si};
      if (lk_cnt_r != CNT_W'(FRAME_W)) begin
        lk_cnt_r <= lk_cnt_r + CNT_W'(1);                         // Saturates past dummy bytes
      end
      if (lk_op_end && lk_op_now == OP_STATUS) begin
        lk_status_r <= 1'b1;
      end
    end
  end

  // Finished frame word and its event toggle survive the select rising
  always_ff @(posedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      lk_word_r <= '0;
      lk_tgl_r  <= 1'b0;
    end else if (!i_cs_n) begin
      if (lk_op_end && sfc_no_addr(lk_op_now)) begin
        lk_word_r <= {lk_op_now, {ADDR_W{1'b0}}};
        lk_tgl_r  <= ~lk_tgl_r;
      end else if (lk_addr_end && !sfc_no_addr(lk_shift_r[FRAME_W-2 -: OP_W])) begin
        lk_word_r <= {lk_shift_r[FRAME_W-2:0], i_si};
        lk_tgl_r  <= ~lk_tgl_r;
      end
    end
  end

  // Standby level carried into the serial clock domain for the status byte
  sfc_sync #(
    .W (1)
  ) u_sync_lk (
    .i_clk  (i_sck),
    .i_nrst (i_nrst),
    .i_d    (o_standby),
    .o_q    (lk_ready_s)
  );

  // Output driven on falling edges, only after a status opcode; idle otherwise
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_so_oe <= 1'b0;
      o_so    <= 1'b0;
      lk_tx_r <= BYTE_RST;
    end else if (lk_status_r && !o_so_oe) begin
      o_so_oe <= 1'b1;
      o_so    <= lk_ready_s;
      lk_tx_r <= BYTE_RST;
    end else if (o_so_oe) begin
      o_so    <= lk_tx_r[STAT_READY];                             // Second byte: ready then 0; third: 0 then ready; fourth on: ready level in every bit
      lk_tx_r <= {lk_tx_r[6:0], lk_ready_s};
    end
  end

  // ---------------- Core domain ----------------
  logic                 cs_s;
  logic                 sck_s;
  logic                 por_s;
  logic                 tgl_s;
  logic                 cs_prev_r;
  logic                 tgl_prev_r;
  logic                 armed_r;
  logic                 pend_r;
  sfc_pwr_t             pwr_r;
  logic [PUW_CNT_W-1:0] puw_cnt_r;
  logic                 frame_evt;
  logic                 take;
  logic                 dec_is_pe;
  logic [PAGE_W-1:0]    dec_page;
  logic [OFF_W-1:0]     dec_off;
  logic                 dec_has_page;
  logic                 dec_has_off;
  logic                 dec_known;

  // Select, clock and power-on reset pins and the link event toggle enter through two flops
  sfc_sync #(
    .W (4)
  ) u_sync_core (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    ({i_cs_n, i_sck, i_por, lk_tgl_r}),
    .o_q    ({cs_s, sck_s, por_s, tgl_s})
  );

  // Word is stable long before the toggle is seen, so it is read directly
  sfc_addr_dec u_dec (
    .i_op       (lk_word_r[FRAME_W-1 -: OP_W]),
    .i_addr     (lk_word_r[ADDR_W-1:0]),
    .i_rmw      (i_rmw_sel),
    .o_page     (dec_page),
    .o_off      (dec_off),
    .o_has_page (dec_has_page),
    .o_has_off  (dec_has_off),
    .o_known    (dec_known)
  );

  assign frame_evt = tgl_s ^ tgl_prev_r;
  assign dec_is_pe = sfc_is_pe(lk_word_r[FRAME_W-1 -: OP_W]);
  assign take      = frame_evt && armed_r && (pwr_r == PWR_STANDBY) && !por_s;

  // Edge history of select and link toggle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_prev_r  <= 1'b1;
      tgl_prev_r <= 1'b0;
    end else if (i_ce) begin
      cs_prev_r  <= cs_s;
      tgl_prev_r <= tgl_s;
    end
  end

  // Power state: held off during power-on reset, standby once it releases
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pwr_r <= PWR_OFF;
    end else if (i_ce) begin
      case (pwr_r)
        PWR_OFF:     pwr_r <= por_s ? PWR_OFF : PWR_STANDBY;
        PWR_STANDBY: pwr_r <= por_s ? PWR_OFF : PWR_STANDBY;
        default:     pwr_r <= PWR_OFF;
      endcase
    end
  end

  // Arm only after select has been seen high, so a frame needs a real fall
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      armed_r <= 1'b0;
    end else if (i_ce) begin
      if (pwr_r != PWR_STANDBY || por_s) begin
        armed_r <= 1'b0;
      end else if (cs_s) begin
        armed_r <= 1'b1;
      end
    end
  end

  // Serial mode: mode 3 out of reset and while off, re-chosen at every select fall in standby
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mode3 <= MODE3_RST;
    end else if (i_ce) begin
      if (pwr_r != PWR_STANDBY) begin
        o_mode3 <= MODE3_RST;
      end else if (cs_prev_r && !cs_s) begin
        o_mode3 <= sck_s;
      end
    end
  end

  // Program/erase delay after power-up; a long count, shortened by parameter in simulation
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      puw_cnt_r    <= '0;
      o_pe_allowed <= 1'b0;
    end else if (i_ce) begin
      if (pwr_r != PWR_STANDBY) begin
        puw_cnt_r    <= '0;
        o_pe_allowed <= 1'b0;
      end else if (!o_pe_allowed) begin
        if (puw_cnt_r >= PUW_CNT_W'(PUW_CYCLES - 1)) begin
          o_pe_allowed <= 1'b1;
        end else begin
          puw_cnt_r <= puw_cnt_r + PUW_CNT_W'(1);
        end
      end
    end
  end

  // Capture decoded fields of each accepted frame
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_opcode     <= BYTE_RST;
      o_page       <= '0;
      o_offset     <= '0;
      o_has_page   <= 1'b0;
      o_has_offset <= 1'b0;
      o_cmd_known  <= 1'b0;
    end else if (i_ce && take && !pend_r) begin
      o_opcode     <= lk_word_r[FRAME_W-1 -: OP_W];
      o_page       <= dec_page;
      o_offset     <= dec_off;
      o_has_page   <= dec_has_page;
      o_has_offset <= dec_has_off;
      o_cmd_known  <= dec_known;
    end
  end

  // Early program/erase is held until the delay ends; frames arriving meanwhile are dropped, others issue at once
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend_r      <= 1'b0;
      o_cmd_valid <= 1'b0;
    end else if (i_ce) begin
      o_cmd_valid <= 1'b0;
      if (pwr_r != PWR_STANDBY || por_s) begin
        pend_r <= 1'b0;
      end else if (pend_r) begin
        if (o_pe_allowed) begin
          pend_r      <= 1'b0;
          o_cmd_valid <= 1'b1;
        end
      end else if (take) begin
        if (dec_is_pe && !o_pe_allowed) begin
          pend_r <= 1'b1;
        end else begin
          o_cmd_valid <= 1'b1;
        end
      end
    end
  end

  // Standby flag from the power state, masked by the synced power-on reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_standby <= 1'b0;
    end else if (i_ce) begin
      o_standby <= (pwr_r == PWR_STANDBY) && !por_s;
    end
  end

endmodule // sfc_top

// ==== verif/sfc_top_sva.sv ====
// Concurrent checks on the ports of the serial flash command front end
`timescale 1ns/1ps
module sfc_top_sva
  import sfc_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_nrst,
  input wire logic              i_por,
  input wire logic              i_rmw_sel,
  input wire logic              i_cs_n,
  input wire logic              o_so_oe,
  input wire logic              o_cmd_valid,
  input wire logic [OP_W-1:0]   o_opcode,
  input wire logic [OFF_W-1:0]  o_offset,
  input wire logic              o_has_page,
  input wire logic              o_has_offset,
  input wire logic              o_mode3,
  input wire logic              o_standby,
  input wire logic              o_pe_allowed
);
  // One core domain, so clock and reset are given once
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  chk_valid_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("command strobe held too long");
  // First edge after release still shows the reset state
  chk_reset_state: assert property ($rose(i_nrst) |-> o_mode3 && !o_so_oe && !o_standby)
    else $error("wrong state after reset");
  chk_por_quiet: assert property (i_por[*8] |-> !o_cmd_valid && !o_standby)
    else $error("activity while power-on reset held");
  chk_pe_gate: assert property (o_cmd_valid && (o_opcode inside {8'h02, 8'h50, 8'h58, 8'h59,
    8'h7c, 8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h88, 8'h89}) |-> o_pe_allowed)
    else $error("program or erase before delay");
  // Four quiet cycles cover the synchroniser on the reset level
  chk_standby_hold: assert property ((!i_por)[*4] ##0 o_standby |=> o_standby)
    else $error("standby lost without reset");
  chk_mode_stable: assert property ((i_cs_n && !i_por)[*8] |=> $stable(o_mode3))
    else $error("mode changed without select fall");
  chk_noaddr_fields: assert property (o_cmd_valid && (o_opcode inside {8'h79, 8'h9f, 8'hb9,
    8'hab, 8'hb0, 8'hd0, 8'hd7}) |-> !o_has_page && !o_has_offset)
    else $error("address flags on addressless opcode");
  chk_rewrite_split: assert property (o_cmd_valid && (o_opcode inside {8'h58, 8'h59})
    && $stable(i_rmw_sel) |-> o_has_page && (o_has_offset == i_rmw_sel)
    && (i_rmw_sel || o_offset == '0))
    else $error("rewrite address split wrong");
  chk_oe_released: assert property (i_cs_n[*3] |-> !o_so_oe)
    else $error("output driven while deselected");

  cover property (o_cmd_valid && !o_mode3);
  cover property (o_so_oe);
  cover property (o_cmd_valid && o_opcode == 8'h58 && o_has_offset);
endmodule // sfc_top_sva

bind sfc_top sfc_top_sva i_sfc_top_sva (.i_clk, .i_nrst, .i_por, .i_rmw_sel, .i_cs_n,
  .o_so_oe, .o_cmd_valid, .o_opcode, .o_offset, .o_has_page, .o_has_offset, .o_mode3,
  .o_standby, .o_pe_allowed);

// ==== verif/sfc_spi_host.sv ====
// SPI host model that frames commands towards the flash front end
`timescale 1ns/1ps
module sfc_spi_host (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so
);
  logic [15:0] rd_r;  // Bits read back, last one in bit 0

  // Select stays high and the clock still between frames
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b1;
    o_si   = 1'b0;
  end

  // One frame, select falls at the idle clock level
  task automatic xfer(input logic [39:0] frm, input int nb, input logic m3);
    #1.7 o_sck = m3;  // Odd offset keeps link edges off the core grid
    #15 o_cs_n = 1'b0;
    for (int k = 0; k < nb; k++) begin
      #15 o_sck = 1'b0;
      o_si = frm[39-k];
      #15 o_sck = 1'b1;
      rd_r = {rd_r[14:0], i_so};
    end
    #15 o_sck = m3;
    o_si = ~o_si;  // Released line shows no stale bit
    #15 o_cs_n = 1'b1;
  endtask
endmodule // sfc_spi_host

// ==== verif/sfc_top_tb_top.sv ====
// Self-checking testbench of the serial flash command front end
`timescale 1ns/1ps
module sfc_top_tb_top;
  import sfc_pkg::*;
  localparam int PUW = 400;  // Short power-up wait, longer than one frame
  logic              i_clk = 1'b0, i_nrst = 1'b0, i_por = 1'b0, i_rmw_sel = 1'b0;
  logic              i_sck, i_cs_n, i_si, so_line, pe_at_end;
  logic              o_so, o_so_oe, o_cmd_valid, o_has_page, o_has_offset, o_cmd_known;
  logic              o_mode3, o_standby, o_pe_allowed;
  logic [OP_W-1:0]   o_opcode;
  logic [PAGE_W-1:0] o_page;
  logic [OFF_W-1:0]  o_offset;
  int                n_fail = 0, cmp_count = 0, n_valid = 0, cyc = 0;

  sfc_top #(.PUW_CYCLES(PUW)) i_sfc_top (.i_clk, .i_nrst, .i_ce(1'b1), .i_por, .i_rmw_sel,
    .i_sck, .i_cs_n, .i_si, .o_so, .o_so_oe, .o_cmd_valid, .o_opcode, .o_page, .o_offset,
    .o_has_page, .o_has_offset, .o_cmd_known, .o_mode3, .o_standby, .o_pe_allowed);
  // Undriven line reads as garbage, never as a lucky match
  assign so_line = o_so_oe ? o_so : ~o_so;
  sfc_spi_host i_sfc_spi_host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si), .i_so(so_line));

  always #2.5 i_clk = ~i_clk;

  // Strobe counter and hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (o_cmd_valid === 1'b1) n_valid++;
    if (cyc == 30000) begin
      n_fail++;
      $display("MISMATCH %0t run too long", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Frame, then wait bounded for a strobe (pending erase may hold it)
  task automatic send(input logic [39:0] f, input int nb, input logic m3, input logic want);
    int n0;
    n0 = n_valid;
    i_sfc_spi_host.xfer(f, nb, m3);
    pe_at_end = o_pe_allowed;
    repeat (600) @(negedge i_clk) if (n_valid != n0) break;
    chk(16'(n_valid != n0), 16'(want), "accepted");
  endtask

  task automatic t_reset();
    repeat (10) @(negedge i_clk);
    chk(o_mode3, 1, "mode");
    chk(o_so_oe, 0, "so idle");
    chk(o_standby, 1, "standby");
    chk(o_pe_allowed, 0, "pe early");
  endtask

  // Reserved bits set, extra dummy byte, both modes
  task automatic t_fields();
    logic [11:0] pg;
    for (int m = 1; m >= 0; m--) begin
      pg = m ? 12'h5a3 : 12'ha5c;
      send({8'h03, 3'b111, pg, 9'h1b3, 8'hff}, 40, m[0], 1);
      chk(o_opcode, 8'h03, "opcode");
      chk(o_page, pg, "page");
      chk(o_offset, 9'h1b3, "offset");
      chk(o_mode3, m[0], "mode");
      chk(o_cmd_known, 1, "known");
    end
    // Opcode outside the table still completes after four bytes
    send({8'hee, 32'h0}, 32, 1, 1);
    chk(o_cmd_known, 0, "unknown");
    chk({o_has_page, o_has_offset}, 0, "unknown flags");
  endtask

  task automatic t_noaddr();
    logic [7:0] ops [7] = '{8'h79, 8'h9f, 8'hb9, 8'hab, 8'hb0, 8'hd0, 8'hd7};
    foreach (ops[i]) begin
      send({ops[i], 32'h0}, 8, 1, 1);
      chk(o_opcode, ops[i], "opcode");
      chk({o_has_page, o_has_offset}, 0, "flags");
    end
  endtask

  task automatic t_status();
    send({8'hd7, 32'h0}, 16, 0, 1);
    chk(i_sfc_spi_host.rd_r[7:0], 8'h80, "status");
    repeat (4) @(negedge i_clk);
    chk(o_so_oe, 0, "released");
    send({8'h03, 32'h0}, 20, 1, 0);
  endtask

  task automatic t_mask();
    logic [7:0]  ops [3] = '{8'h50, 8'h7c, 8'h81};
    logic [11:0] exp [3] = '{12'hff8, 12'hf00, 12'hfff};
    foreach (ops[i]) begin
      send({ops[i], 3'b000, 12'hfff, 9'h1ff, 8'h00}, 32, 1, 1);
      chk(o_page, exp[i], "page");
      chk(o_offset, 0, "offset");
    end
  endtask

  task automatic t_rewrite();
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 2; k++) begin
        @(negedge i_clk) i_rmw_sel = r[0];
        send({8'h58 + 8'(k), 3'b000, 12'h3c7, 9'h0f5, 8'h00}, 32, 1, 1);
        chk(o_page, 12'h3c7, "page");
        chk(o_offset, r ? 9'h0f5 : 9'h000, "offset");
        chk(o_has_offset, r[0], "has offset");
      end
    end
  endtask

  task automatic t_por();
    @(negedge i_clk) i_por = 1'b1;
    repeat (10) @(negedge i_clk);
    chk(o_standby, 0, "standby");
    chk(o_mode3, 1, "mode");
    send({8'h03, 32'h0}, 32, 1, 0);
    i_por = 1'b0;
    repeat (10) @(negedge i_clk);
    chk(o_standby, 1, "standby");
    send({8'h81, 3'b000, 12'h012, 9'h000, 8'h00}, 32, 1, 1);
    chk(pe_at_end, 0, "pe at frame end");
    chk(o_pe_allowed, 1, "pe allowed");
    chk(o_page, 12'h012, "page");
  endtask

  initial begin
    repeat (12) @(negedge i_clk);
    i_nrst = 1'b1;
    t_reset();
    t_fields();
    t_noaddr();
    t_status();
    t_mask();
    t_rewrite();
    t_por();
    tally_and_finish();
  end
endmodule // sfc_top_tb_top
